// ===== inc/uts_pkg.sv
package uts_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
	localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
	localparam logic [7:0] ADDR_DIVISOR = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_TX_BUF = 8'h10;
	localparam logic [7:0] ADDR_RX_BUF = 8'h14;
	// values after reset
	localparam logic [7:0] CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] CTRL_TWO_RST = 8'h00;
	localparam logic [7:0] DIVISOR_RST = 8'h00;
	// serial_control_one fields
	localparam int unsigned C1_TXE = 0;
	localparam int unsigned C1_RXE = 1;
	localparam int unsigned C1_BRG_LO = 2;
	localparam int unsigned C1_STOP_BIT_COUNT = 4;
	localparam int unsigned C1_PE = 5;
	localparam int unsigned C1_IRDA = 6;
	// serial_control_two fields
	localparam int unsigned C2_BIT_LENGTH_SEL_LO = 0;
	localparam int unsigned C2_FILT_LO = 3;
	// serial_status_reg fields
	localparam int unsigned ST_RX_BUFFER_FULL_FLAG = 0;
	localparam int unsigned ST_PARITY_ERROR_FLAG = 1;
	localparam int unsigned ST_FRAMING_ERROR_FLAG = 2;
	localparam int unsigned ST_OVERRUN_ERROR_FLAG = 3;
	localparam int unsigned ST_TX_BUFFER_FULL_FLAG = 4;
	localparam int unsigned ST_TX_BUSY_FLAG = 5;
	// bit timing in base ticks
	localparam logic [4:0] RT_SAMPLE_A = 5'h08;
	localparam logic [4:0] RT_SAMPLE_B = 5'h07;
	localparam logic [4:0] RT_SAMPLE_C = 5'h06;
	localparam logic [4:0] IRDA_PULSE_RT = 5'h03;
	localparam logic [4:0] RT_LEN_15 = 5'h0F;
	localparam logic [4:0] RT_LEN_16 = 5'h10;
	localparam logic [4:0] RT_LEN_17 = 5'h11;
	localparam logic [3:0] FRAME_BASE_LAST = 4'h9;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ticks per bit for a bit_length_sel value and bit index
	function automatic logic [4:0] uts_bit_len(input logic [2:0] sel, input logic [3:0] idx);
		logic [4:0] len;
		case (sel)
			3'h1: len = idx[0] ? RT_LEN_17 : RT_LEN_16;
			3'h2: len = RT_LEN_15;
			3'h3: len = idx[0] ? RT_LEN_16 : RT_LEN_15;
			3'h4: len = RT_LEN_17;
			default: len = RT_LEN_16;
		endcase
		return len;
	endfunction
endpackage

// ===== hdl/uts_tick.sv
`timescale 1ns/1ps
module uts_tick
	import uts_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// settings
	input wire logic [1:0] baud_clock_sel,
	input wire logic [7:0] baud_divisor,
	// base tick
	output logic transfer_base_tick
);
	logic [2:0] pre_r, pre_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic tick_r, tick_nxt;
	logic src;

	// prescale then divide by divisor plus one
	always_comb
	begin
		pre_nxt = pre_r + 3'h1;
		src = (baud_clock_sel == 2'h0) || (baud_clock_sel == 2'h1 && pre_r[0])
			|| (baud_clock_sel == 2'h2 && &pre_r[1:0]) || (baud_clock_sel == 2'h3 && &pre_r);
		cnt_nxt = cnt_r;
		tick_nxt = 1'b0;
		if (src)
		begin
			if (cnt_r >= baud_divisor) // see R17
			begin
				cnt_nxt = 8'h00;
				tick_nxt = 1'b1;
			end
			else
				cnt_nxt = cnt_r + 8'h01;
		end
	end

	// registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pre_r <= 3'h0;
			cnt_r <= 8'h00;
			tick_r <= 1'b0;
		end
		else
		begin
			pre_r <= pre_nxt;
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end
	assign transfer_base_tick = tick_r;

	tick_gap_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R17
		(baud_divisor != 8'h00 && $stable(baud_divisor) && tick_r) |=> !tick_r)
		else $error("base tick repeated with divisor above zero");
endmodule // uts_tick

// ===== hdl/uts_rx.sv
`timescale 1ns/1ps
module uts_rx
	import uts_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// line and timing
	input wire logic serial_in_pin,
	input wire logic transfer_base_tick,
	// settings
	input wire logic receive_enable,
	input wire logic [1:0] rx_noise_filter_sel,
	input wire logic [2:0] bit_length_sel,
	input wire logic parity_enable,
	input wire logic stop_bit_count,
	// received frame
	output logic frame_done,
	output logic [7:0] frame_data,
	output logic parity_bad,
	output logic stop_bad
);
	typedef enum logic {RX_IDLE, RX_RUN} uts_rx_e;
	uts_rx_e st_r, st_nxt;
	logic filt_r, filt_nxt, prev_r, prev_nxt;
	logic [2:0] fcnt_r, fcnt_nxt, need;
	logic [4:0] rt_r, rt_nxt;
	logic [3:0] idx_r, idx_nxt, last;
	logic [1:0] samp_r, samp_nxt;
	logic [7:0] data_r, data_nxt;
	logic pbit_r, pbit_nxt, sbad_r, sbad_nxt, done_r, done_nxt, pbad_r, pbad_nxt;
	logic maj;

	// noise filter, edge search and bit sampling
	always_comb
	begin
		need = (rx_noise_filter_sel == 2'h1) ? 3'h1 : (rx_noise_filter_sel == 2'h2) ? 3'h2 : 3'h4;
		filt_nxt = filt_r;
		fcnt_nxt = fcnt_r;
		if (rx_noise_filter_sel == 2'h0) // see R01
			filt_nxt = serial_in_pin;
		else if (serial_in_pin == filt_r)
			fcnt_nxt = 3'h0;
		else if (transfer_base_tick)
		begin
			if (fcnt_r + 3'h1 >= need) // see R01
			begin
				filt_nxt = serial_in_pin;
				fcnt_nxt = 3'h0;
			end
			else
				fcnt_nxt = fcnt_r + 3'h1;
		end
		prev_nxt = filt_r;
		last = FRAME_BASE_LAST + {3'h0, parity_enable} + {3'h0, stop_bit_count};
		maj = (samp_r[1] & samp_r[0]) | (samp_r[1] & filt_r) | (samp_r[0] & filt_r); // see R18
		st_nxt = st_r;
		rt_nxt = rt_r;
		idx_nxt = idx_r;
		samp_nxt = samp_r;
		data_nxt = data_r;
		pbit_nxt = pbit_r;
		sbad_nxt = sbad_r;
		done_nxt = 1'b0;
		pbad_nxt = pbad_r;
		case (st_r)
			RX_IDLE:
			begin
				if (receive_enable && prev_r && !filt_r) // see R18
				begin
					st_nxt = RX_RUN;
					idx_nxt = 4'h0;
					rt_nxt = uts_bit_len(bit_length_sel, 4'h0) - 5'h01;
					sbad_nxt = 1'b0;
				end
			end
			RX_RUN:
			begin
				if (!receive_enable)
					st_nxt = RX_IDLE;
				else if (transfer_base_tick)
				begin
					rt_nxt = rt_r - 5'h01;
					if (rt_r == RT_SAMPLE_A || rt_r == RT_SAMPLE_B)
						samp_nxt = {samp_r[0], filt_r};
					if (rt_r == RT_SAMPLE_C)
					begin
						if (idx_r == 4'h0)
						begin
							if (maj)
								st_nxt = RX_IDLE; // see R19
						end
						else if (idx_r <= 4'h8)
							data_nxt = {maj, data_r[7:1]};
						else if (parity_enable && idx_r == 4'h9)
							pbit_nxt = maj;
						else if (!maj)
							sbad_nxt = 1'b1; // see R11
						if (idx_r == last)
						begin
							st_nxt = RX_IDLE; // see R06
							done_nxt = 1'b1;
							pbad_nxt = parity_enable && ((^data_r) != pbit_r); // see R10
							sbad_nxt = sbad_r | !maj;
						end
					end
					if (rt_r == 5'h00)
					begin
						idx_nxt = idx_r + 4'h1;
						rt_nxt = uts_bit_len(bit_length_sel, idx_r + 4'h1) - 5'h01; // see R16
					end
				end
			end
			default: st_nxt = RX_IDLE;
		endcase
	end

	// registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r <= RX_IDLE;
			filt_r <= 1'b1;
			prev_r <= 1'b1;
			fcnt_r <= 3'h0;
			rt_r <= 5'h00;
			idx_r <= 4'h0;
			samp_r <= 2'h0;
			data_r <= 8'h00;
			pbit_r <= 1'b0;
			sbad_r <= 1'b0;
			done_r <= 1'b0;
			pbad_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			filt_r <= filt_nxt;
			prev_r <= prev_nxt;
			fcnt_r <= fcnt_nxt;
			rt_r <= rt_nxt;
			idx_r <= idx_nxt;
			samp_r <= samp_nxt;
			data_r <= data_nxt;
			pbit_r <= pbit_nxt;
			sbad_r <= sbad_nxt;
			done_r <= done_nxt;
			pbad_r <= pbad_nxt;
		end
	end
	assign frame_done = done_r;
	assign frame_data = data_r;
	assign parity_bad = pbad_r;
	assign stop_bad = sbad_r;

	start_abort_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R19
		(st_r == RX_RUN && receive_enable && transfer_base_tick && idx_r == 4'h0
		&& rt_r == RT_SAMPLE_C && maj) |=> st_r == RX_IDLE && !done_r)
		else $error("start bit sampled high did not abandon the frame");
	filter_bypass_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R01
		(rx_noise_filter_sel == 2'h0) |=> filt_r == $past(serial_in_pin))
		else $error("unfiltered input not followed");
	abort_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
		st_r == RX_RUN ##1 st_r == RX_IDLE && !done_r);
endmodule // uts_rx

// ===== hdl/uts_core.sv
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Operation
// R01: filter rejects pulses under 1/2/4 ticks
// R02: buffer write starts framed byte transmission
// R03: frame start clears full flag, irq
// R04: rewrite before transfer replaces pending byte
// R05: idle pin level follows infrared select
// R06: received byte loads buffer, full flag, irq
// R07: frame over full buffer sets overrun
// R08: overrun set: frames dropped, no irq
// R09: error flags describe stored byte only
// R10: parity mismatch sets flag and irq
// R11: zero stop bit sets framing flag
// R12: flags clear by status then buffer read
// R13: data read after parity clear undefined
// R14: busy clears when idle, sets on restart
// R15: infrared mode emits 3/16 bit pulses
// R16: bit length 15, 16, 17 or alternating
// R17: base tick every divisor plus one
// R18: start on falling edge, majority sampling
// R19: high start sample abandons the frame
// R20: interrupt requests are one-cycle pulses
// R21: remote sends matching format, idle high
module uts_core
	import uts_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// serial line and power state
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	input wire logic power_stop,
	// interrupt requests
	output logic tx_irq,
	output logic rx_irq
);
	typedef enum logic {TX_IDLE, TX_SHIFT} uts_tx_e;
	logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
	logic [7:0] awa_r, awa_nxt, wd_r, wd_nxt;
	logic ws_r, ws_nxt;
	logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic [7:0] c1_r, c1_nxt, c2_r, c2_nxt, div_r, div_nxt, txb_r, txb_nxt, rxb_r, rxb_nxt;
	logic tx_buffer_full_flag_r, tx_buffer_full_flag_nxt, tx_busy_flag_r, tx_busy_flag_nxt;
	logic rx_buffer_full_flag_r, rx_buffer_full_flag_nxt, parity_error_flag_r, parity_error_flag_nxt, framing_error_flag_r, framing_error_flag_nxt, overrun_error_flag_r, overrun_error_flag_nxt;
	logic [3:0] snap_r, snap_nxt;
	logic txi_r, txi_nxt, rxi_r, rxi_nxt;
	uts_tx_e tst_r, tst_nxt;
	logic [11:0] shf_r, shf_nxt;
	logic [3:0] idx_r, idx_nxt, tlast;
	logic [4:0] el_r, el_nxt, tlen;
	logic out_r, out_nxt;
	logic do_wr, wr_txbuf, rd_hs, rd_rxbuf, tx_start, frame_end, tx_on, bitv;
	logic rx_buffer_full_flag_eff, overrun_error_flag_eff;
	logic tick, rx_done, rx_pbad, rx_sbad;
	logic [7:0] rx_data;
	logic [5:0] status;

	// base tick generator
	uts_tick u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.baud_clock_sel(c1_r[C1_BRG_LO +: 2]),
		.baud_divisor(div_r),
		.transfer_base_tick(tick)
	);

	// receiver
	uts_rx u_rx (
		.aclk(aclk),
		.aresetn(aresetn),
		.serial_in_pin(serial_in_pin),
		.transfer_base_tick(tick),
		.receive_enable(c1_r[C1_RXE]),
		.rx_noise_filter_sel(c2_r[C2_FILT_LO +: 2]),
		.bit_length_sel(c2_r[C2_BIT_LENGTH_SEL_LO +: 3]),
		.parity_enable(c1_r[C1_PE]),
		.stop_bit_count(c1_r[C1_STOP_BIT_COUNT]),
		.frame_done(rx_done),
		.frame_data(rx_data),
		.parity_bad(rx_pbad),
		.stop_bad(rx_sbad)
	);

	// bus handshakes and strobes
	assign awready = !aw_r;
	assign wready = !w_r;
	assign arready = !rv_r;
	assign do_wr = aw_r && w_r && !bv_r;
	assign wr_txbuf = do_wr && ws_r && awa_r == ADDR_TX_BUF;
	assign rd_hs = arvalid && !rv_r;
	assign rd_rxbuf = rd_hs && araddr == ADDR_RX_BUF;
	assign status = {tx_busy_flag_r, tx_buffer_full_flag_r, overrun_error_flag_r, framing_error_flag_r, parity_error_flag_r, rx_buffer_full_flag_r};
	// transmitter timing terms
	assign tx_on = c1_r[C1_TXE] && !power_stop;
	assign tlen = uts_bit_len(c2_r[C2_BIT_LENGTH_SEL_LO +: 3], idx_r); // see R16
	assign tlast = FRAME_BASE_LAST + {3'h0, c1_r[C1_PE]} + {3'h0, c1_r[C1_STOP_BIT_COUNT]};
	assign frame_end = tst_r == TX_SHIFT && tick && el_r == tlen - 5'h01 && idx_r == tlast;
	assign tx_start = tx_buffer_full_flag_r && tx_on && (tst_r == TX_IDLE || frame_end); // see R02

	// axi slave, registers and flags
	always_comb
	begin
		aw_nxt = aw_r | awvalid;
		awa_nxt = aw_r ? awa_r : awaddr;
		w_nxt = w_r | wvalid;
		wd_nxt = w_r ? wd_r : wdata[7:0];
		ws_nxt = w_r ? ws_r : wstrb[0];
		bv_nxt = bv_r && !bready;
		br_nxt = br_r;
		rv_nxt = rv_r && !rready;
		rd_nxt = rd_r;
		rr_nxt = rr_r;
		c1_nxt = c1_r;
		c2_nxt = c2_r;
		div_nxt = div_r;
		txb_nxt = txb_r;
		tx_buffer_full_flag_nxt = tx_buffer_full_flag_r;
		rxb_nxt = rxb_r;
		rx_buffer_full_flag_nxt = rx_buffer_full_flag_r;
		parity_error_flag_nxt = parity_error_flag_r;
		framing_error_flag_nxt = framing_error_flag_r;
		overrun_error_flag_nxt = overrun_error_flag_r;
		snap_nxt = snap_r;
		rxi_nxt = 1'b0;
		if (tx_start)
			tx_buffer_full_flag_nxt = 1'b0; // see R03
		if (do_wr)
		begin
			aw_nxt = 1'b0;
			w_nxt = 1'b0;
			bv_nxt = 1'b1;
			br_nxt = RESP_OKAY;
			if (awa_r == ADDR_CTRL_ONE)
				c1_nxt = ws_r ? wd_r : c1_r;
			else if (awa_r == ADDR_CTRL_TWO)
				c2_nxt = ws_r ? wd_r : c2_r;
			else if (awa_r == ADDR_DIVISOR)
				div_nxt = ws_r ? wd_r : div_r;
			else if (awa_r == ADDR_TX_BUF)
			begin
				if (ws_r)
				begin
					txb_nxt = wd_r; // see R04
					tx_buffer_full_flag_nxt = 1'b1; // see R03
				end
			end
			else if (awa_r != ADDR_STATUS && awa_r != ADDR_RX_BUF)
				br_nxt = RESP_SLVERR;
		end
		if (rd_hs)
		begin
			rv_nxt = 1'b1;
			rr_nxt = RESP_OKAY;
			rd_nxt = 32'h0000_0000;
			if (araddr == ADDR_CTRL_ONE)
				rd_nxt[7:0] = c1_r;
			else if (araddr == ADDR_CTRL_TWO)
				rd_nxt[7:0] = c2_r;
			else if (araddr == ADDR_DIVISOR)
				rd_nxt[7:0] = div_r;
			else if (araddr == ADDR_STATUS)
			begin
				rd_nxt[5:0] = status;
				snap_nxt = status[3:0]; // see R12
			end
			else if (araddr == ADDR_RX_BUF)
			begin
				rd_nxt[7:0] = rxb_r; // see R13
				rx_buffer_full_flag_nxt = rx_buffer_full_flag_r && !snap_r[ST_RX_BUFFER_FULL_FLAG]; // see R12
				parity_error_flag_nxt = parity_error_flag_r && !snap_r[ST_PARITY_ERROR_FLAG];
				framing_error_flag_nxt = framing_error_flag_r && !snap_r[ST_FRAMING_ERROR_FLAG];
				overrun_error_flag_nxt = overrun_error_flag_r && !snap_r[ST_OVERRUN_ERROR_FLAG];
				snap_nxt = 4'h0;
			end
			else if (araddr != ADDR_TX_BUF)
				rr_nxt = RESP_SLVERR;
		end
		// a finished frame is judged after any clear in this cycle
		rx_buffer_full_flag_eff = rx_buffer_full_flag_nxt;
		overrun_error_flag_eff = overrun_error_flag_nxt;
		if (rx_done)
		begin
			if (overrun_error_flag_eff)
				rxi_nxt = 1'b0; // see R08
			else if (rx_buffer_full_flag_eff)
			begin
				overrun_error_flag_nxt = 1'b1; // see R07
				rxi_nxt = 1'b1;
			end
			else
			begin
				rxb_nxt = rx_data; // see R06
				rx_buffer_full_flag_nxt = 1'b1;
				parity_error_flag_nxt = parity_error_flag_nxt | rx_pbad; // see R09 R10
				framing_error_flag_nxt = framing_error_flag_nxt | rx_sbad; // see R09 R11
				rxi_nxt = 1'b1; // see R20
			end
		end
	end

	// transmit shifter and pin
	always_comb
	begin
		tst_nxt = tst_r;
		shf_nxt = shf_r;
		idx_nxt = idx_r;
		el_nxt = el_r;
		tx_busy_flag_nxt = tx_busy_flag_r;
		txi_nxt = tx_start; // see R20
		if (!tx_on)
		begin
			tst_nxt = TX_IDLE;
			tx_busy_flag_nxt = 1'b0;
		end
		else if (tx_start)
		begin
			tst_nxt = TX_SHIFT;
			shf_nxt = c1_r[C1_PE] ? {2'h3, ^txb_r, txb_r, 1'b0} : {3'h7, txb_r, 1'b0}; // see R02
			idx_nxt = 4'h0;
			el_nxt = 5'h00;
			tx_busy_flag_nxt = 1'b1; // see R14
		end
		else if (frame_end)
		begin
			tst_nxt = TX_IDLE;
			tx_busy_flag_nxt = 1'b0; // see R14
		end
		else if (tst_r == TX_SHIFT && tick)
		begin
			if (el_r == tlen - 5'h01)
			begin
				idx_nxt = idx_r + 4'h1;
				el_nxt = 5'h00;
			end
			else
				el_nxt = el_r + 5'h01;
		end
		bitv = (tst_r == TX_SHIFT) ? shf_r[idx_r] : 1'b1;
		if (!tx_on || tst_r == TX_IDLE)
			out_nxt = !c1_r[C1_IRDA]; // see R05
		else if (c1_r[C1_IRDA])
			out_nxt = !bitv && el_r < IRDA_PULSE_RT; // see R15
		else
			out_nxt = bitv;
	end

	// registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_r <= 1'b0;
			awa_r <= 8'h00;
			w_r <= 1'b0;
			wd_r <= 8'h00;
			ws_r <= 1'b0;
			bv_r <= 1'b0;
			br_r <= RESP_OKAY;
			rv_r <= 1'b0;
			rd_r <= 32'h0000_0000;
			rr_r <= RESP_OKAY;
			c1_r <= CTRL_ONE_RST;
			c2_r <= CTRL_TWO_RST;
			div_r <= DIVISOR_RST;
			txb_r <= 8'h00;
			tx_buffer_full_flag_r <= 1'b0;
			tx_busy_flag_r <= 1'b0;
			rxb_r <= 8'h00;
			rx_buffer_full_flag_r <= 1'b0;
			parity_error_flag_r <= 1'b0;
			framing_error_flag_r <= 1'b0;
			overrun_error_flag_r <= 1'b0;
			snap_r <= 4'h0;
			txi_r <= 1'b0;
			rxi_r <= 1'b0;
			tst_r <= TX_IDLE;
			shf_r <= 12'hFFF;
			idx_r <= 4'h0;
			el_r <= 5'h00;
			out_r <= 1'b1;
		end
		else
		begin
			aw_r <= aw_nxt;
			awa_r <= awa_nxt;
			w_r <= w_nxt;
			wd_r <= wd_nxt;
			ws_r <= ws_nxt;
			bv_r <= bv_nxt;
			br_r <= br_nxt;
			rv_r <= rv_nxt;
			rd_r <= rd_nxt;
			rr_r <= rr_nxt;
			c1_r <= c1_nxt;
			c2_r <= c2_nxt;
			div_r <= div_nxt;
			txb_r <= txb_nxt;
			tx_buffer_full_flag_r <= tx_buffer_full_flag_nxt;
			tx_busy_flag_r <= tx_busy_flag_nxt;
			rxb_r <= rxb_nxt;
			rx_buffer_full_flag_r <= rx_buffer_full_flag_nxt;
			parity_error_flag_r <= parity_error_flag_nxt;
			framing_error_flag_r <= framing_error_flag_nxt;
			overrun_error_flag_r <= overrun_error_flag_nxt;
			snap_r <= snap_nxt;
			txi_r <= txi_nxt;
			rxi_r <= rxi_nxt;
			tst_r <= tst_nxt;
			shf_r <= shf_nxt;
			idx_r <= idx_nxt;
			el_r <= el_nxt;
			out_r <= out_nxt;
		end
	end

	// outputs
	assign bvalid = bv_r;
	assign bresp = br_r;
	assign rvalid = rv_r;
	assign rdata = rd_r;
	assign rresp = rr_r;
	assign serial_out_pin = out_r;
	assign tx_irq = txi_r;
	assign rx_irq = rxi_r;

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	irq_pulse_a: assert property ((tx_irq |=> !tx_irq) and (rx_irq |=> !rx_irq)) // see R20
		else $error("interrupt request wider than one cycle");
	tx_start_a: assert property (tx_start && !wr_txbuf |=> !tx_buffer_full_flag_r && tx_busy_flag_r && tx_irq) // see R03
		else $error("frame start did not clear full flag with busy and irq");
	buf_write_a: assert property (wr_txbuf |=> tx_buffer_full_flag_r && txb_r == $past(wd_r)) // see R04
		else $error("buffer write did not set full flag");
	idle_level_a: assert property (!tx_on && $stable(c1_r) |=> serial_out_pin == !c1_r[C1_IRDA])
		else $error("idle pin level wrong"); // see R05
	overrun_set_a: assert property (rx_done && rx_buffer_full_flag_eff && !overrun_error_flag_eff |=> overrun_error_flag_r && rx_irq && $stable(rxb_r))
		else $error("overrun not flagged or buffer changed"); // see R07
	overrun_drop_a: assert property (rx_done && overrun_error_flag_eff |=> !rx_irq && $stable(rxb_r)) // see R08
		else $error("frame during overrun not silently dropped");
	rx_load_a: assert property (rx_done && !rx_buffer_full_flag_eff && !overrun_error_flag_eff
		|=> rx_buffer_full_flag_r && rx_irq && rxb_r == $past(rx_data)) // see R06
		else $error("received byte not loaded");
	err_stored_a: assert property (rx_done && (rx_buffer_full_flag_eff || overrun_error_flag_eff) && !parity_error_flag_nxt && !framing_error_flag_nxt
		|=> !parity_error_flag_r && !framing_error_flag_r) // see R09
		else $error("error flag set by a discarded frame");
	parity_flag_a: assert property (rx_done && rx_pbad && !rx_buffer_full_flag_eff && !overrun_error_flag_eff |=> parity_error_flag_r) // see R10
		else $error("parity error not flagged");
	framing_flag_a: assert property (rx_done && rx_sbad && !rx_buffer_full_flag_eff && !overrun_error_flag_eff |=> framing_error_flag_r) // see R11
		else $error("framing error not flagged");
	status_clear_a: assert property (rd_rxbuf && rx_buffer_full_flag_r && !snap_r[ST_RX_BUFFER_FULL_FLAG] |=> rx_buffer_full_flag_r) // see R12
		else $error("unobserved full flag cleared");
	irda_width_a: assert property (tx_on && c1_r[C1_IRDA] && tst_r == TX_SHIFT
		&& el_r >= IRDA_PULSE_RT && !tx_start |=> !serial_out_pin) // see R15
		else $error("infrared pulse too long");
	tx_frame_c: cover property (frame_end && !tx_start);
	rx_frame_c: cover property (rx_done && !rx_buffer_full_flag_eff && !overrun_error_flag_eff);
	overrun_c: cover property (rx_done && rx_buffer_full_flag_eff && !overrun_error_flag_eff);
	back_to_back_c: cover property (frame_end && tx_start);
endmodule // uts_core

// ===== verif/uts_remote.sv
`timescale 1ns/1ps
module uts_remote
(
	// clock
	input wire logic aclk,
	// serial lines
	input wire logic tx_line,
	output logic rx_line
);
	parameter int BIT = 16;
	logic [9:0] got[$];
	logic [9:0] v;
	initial rx_line = 1'b1;
	// decode device frames mid-bit: data, parity, stop
	always
	begin
		@(negedge tx_line);
		repeat (8) @(posedge aclk);
		for (int i = 0; i < 10; i++)
		begin
			repeat (BIT) @(posedge aclk);
			v[i] = tx_line;
		end
		got.push_back(v);
	end
	// send one even-parity frame, optionally corrupted, then idle high
	task automatic send(input logic [7:0] d, input logic bp, input logic bs);
		logic [10:0] f;
		f = {~bs, (^d) ^ bp, d, 1'b0};
		for (int i = 0; i < 11; i++)
		begin
			rx_line <= f[i];
			repeat (BIT) @(posedge aclk);
		end
		rx_line <= 1'b1;
		repeat (BIT) @(posedge aclk);
	endtask
endmodule // uts_remote

// ===== verif/uart_txrx_status_core_tb_top.sv
`timescale 1ns/1ps
module uart_txrx_status_core_tb_top
	import uts_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, serial_in_pin, serial_out_pin;
	logic tx_irq, rx_irq;
	logic power_stop = 1'b0;
	logic [1:0] bresp, rresp;
	int num_errors = 0, checked = 0, tx_cnt = 0, rx_cnt = 0;
	always #12.5 aclk = ~aclk;
	uts_core DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .serial_in_pin(serial_in_pin),
		.serial_out_pin(serial_out_pin), .power_stop(power_stop), .tx_irq(tx_irq),
		.rx_irq(rx_irq));
	uts_remote rm (.aclk(aclk), .tx_line(serial_out_pin), .rx_line(serial_in_pin));
	// count interrupt pulses
	always @(posedge aclk)
	begin
		if (tx_irq === 1'b1) tx_cnt++;
		if (rx_irq === 1'b1) rx_cnt++;
	end
	// verdict and end of run
	task end_of_test;
		$display("errors=%0d checks=%0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// axi4-lite write, held until each channel is taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		int n;
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
		if (n == 40) begin num_errors++; end_of_test; end
	endtask
	// axi4-lite read
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
		if (n == 40) begin num_errors++; end_of_test; end
	endtask
	task automatic st(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
	endtask
	// reset state, unmapped access, setup: 16 ticks, divisor 0, tx+rx+parity
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		st(ADDR_STATUS, 32'h0);
		chk(serial_out_pin, 1'b1);
		wr(8'h40, 8'h00, r);
		chk(r, RESP_SLVERR);
		rd(8'h40, d, r);
		chk(r, RESP_SLVERR);
		wr(ADDR_CTRL_TWO, 8'h00, r);
		wr(ADDR_DIVISOR, 8'h00, r);
		wr(ADDR_CTRL_ONE, 8'h23, r);
		repeat (40) @(posedge aclk);
		chk(serial_out_pin, 1'b1);
	endtask
	// back-to-back buffer writes: middle byte overwritten
	task automatic t_tx;
		logic [1:0] r;
		int c0;
		c0 = tx_cnt;
		wr(ADDR_TX_BUF, 8'hA5, r);
		wr(ADDR_TX_BUF, 8'h0F, r);
		st(ADDR_STATUS, 32'h30);
		wr(ADDR_TX_BUF, 8'hC3, r);
		repeat (420) @(posedge aclk);
		chk(rm.got.size(), 2);
		chk(rm.got.pop_front(), {1'b1, ^8'hA5, 8'hA5});
		chk(rm.got.pop_front(), {1'b1, ^8'hC3, 8'hC3});
		chk(tx_cnt - c0, 2);
		st(ADDR_STATUS, 32'h0);
	endtask
	// clean frame received and cleared
	task automatic t_rx;
		int c0;
		c0 = rx_cnt;
		rm.send(8'h3C, 1'b0, 1'b0);
		repeat (4) @(posedge aclk);
		chk(rx_cnt - c0, 1);
		st(ADDR_STATUS, 32'h1);
		st(ADDR_RX_BUF, 32'h3C);
		st(ADDR_STATUS, 32'h0);
	endtask
	// overrun after status snapshot, further frames dropped silently
	task automatic t_over;
		logic [31:0] d;
		logic [1:0] r;
		int c0;
		c0 = rx_cnt;
		rm.send(8'h11, 1'b0, 1'b0);
		repeat (4) @(posedge aclk);
		st(ADDR_STATUS, 32'h1);
		rm.send(8'h22, 1'b0, 1'b0);
		rm.send(8'h33, 1'b0, 1'b0);
		repeat (4) @(posedge aclk);
		chk(rx_cnt - c0, 2);
		st(ADDR_RX_BUF, 32'h11);
		st(ADDR_STATUS, 32'h8);
		rd(ADDR_RX_BUF, d, r);
		st(ADDR_STATUS, 32'h0);
	endtask
	// parity and stop errors; discarded frame sets no error flag
	task automatic t_err;
		logic [31:0] d;
		logic [1:0] r;
		rm.send(8'h5A, 1'b1, 1'b0);
		repeat (4) @(posedge aclk);
		st(ADDR_STATUS, 32'h3);
		rd(ADDR_RX_BUF, d, r); // data not judged
		st(ADDR_STATUS, 32'h0);
		rm.send(8'h5A, 1'b0, 1'b1);
		repeat (4) @(posedge aclk);
		st(ADDR_STATUS, 32'h5);
		rm.send(8'h66, 1'b1, 1'b0);
		repeat (4) @(posedge aclk);
		st(ADDR_STATUS, 32'hD);
		rd(ADDR_RX_BUF, d, r);
		st(ADDR_STATUS, 32'h0);
	endtask
	// infrared pulses on an all-zero byte, then a stop-mode abort mid frame
	task automatic t_irda;
		logic [1:0] r;
		int hi;
		wr(ADDR_CTRL_ONE, 8'h63, r);
		chk(serial_out_pin, 1'b0);
		wr(ADDR_TX_BUF, 8'h00, r);
		hi = 0;
		repeat (200)
		begin
			@(posedge aclk);
			if (serial_out_pin === 1'b1) hi++;
		end
		chk(hi, 30);
		wr(ADDR_CTRL_ONE, 8'h23, r);
		wr(ADDR_TX_BUF, 8'h00, r);
		repeat (20) @(posedge aclk);
		power_stop <= 1'b1;
		repeat (2) @(posedge aclk);
		chk(serial_out_pin, 1'b1);
		power_stop <= 1'b0;
		repeat (2) @(posedge aclk);
		st(ADDR_STATUS, 32'h0);
	endtask
	// main sequence
	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_tx;
		t_rx;
		t_over;
		t_err;
		t_irda;
		end_of_test;
	end
endmodule // uart_txrx_status_core_tb_top
